// File: testbench/psc_far_side.sv
// Far-side model: exception memory and a foreign bus master.
// Assumes the controller holds exc_mem_addr until its next request.
module psc_far_side (
  input wire logic clk_sys, exc_mem_req, acc_done, want_bus,
  input wire logic [23:0] exc_mem_addr,
  output logic [15:0] exc_mem_rdata,
  output logic bus_req
);
  logic live = 1'b0;
  // Data stands only during an access; otherwise inverted junk, so stale reads show.
  wire [15:0] word = exc_mem_addr[15:0] + 16'h1000;
  assign exc_mem_rdata = live ? word : ~word;
  always @(posedge clk_sys) live <= exc_mem_req ? 1'b1 : (acc_done ? 1'b0 : live);
  assign bus_req = want_bus;
endmodule // psc_far_side

// File: testbench/psc_state_ctrl_monitor.sv
// Checker on the processing-state controller ports.
// Assumes it is bound into every psc_state_ctrl instance.
module psc_state_ctrl_monitor #(parameter int AREAS = 8) (
  // Observed ports, several to a line to save space.
  input wire logic clk_sys, resetn, reset_in_n, hw_standby_in_n, wdt_overflow, instr_end, irq_req, irq_nmi,
  input wire logic irq_ack, user_flag_enable, standby_select, bus_req, bus_grant, core_acc_start, acc_busy,
  input wire logic acc_done, sp_load, cpu_run, clock_stop,
  input psc_pkg::psc_instr_type instr_class,
  input psc_pkg::psc_space_type core_acc_space,
  input wire logic [$clog2(AREAS)-1:0] core_acc_area,
  input wire logic [AREAS-1:0] area_slow,
  input wire logic [7:0] condition_flags_reg,
  input wire logic [2:0] proc_class
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // No reset or standby source overrides this cycle, so normal sequencing applies.
  wire calm = reset_in_n && hw_standby_in_n && !wdt_overflow;
  wire ended = instr_end && cpu_run && calm;
  wire go = core_acc_start && !acc_busy && cpu_run && calm;
  wire slow = core_acc_space == psc_pkg::PSC_SPACE_PERIPH
    || core_acc_space == psc_pkg::PSC_SPACE_EXTERNAL && area_slow[core_acc_area];
  chk_pin_reset: assert property (hw_standby_in_n && (!reset_in_n || wdt_overflow) |=> !cpu_run && proc_class == psc_pkg::PSC_CLASS_RESET)
    else $error("reset source ignored");
  chk_grant_cause: assert property ($rose(bus_grant) |-> $past(bus_req))
    else $error("grant without request");
  chk_fast_access: assert property (go && !slow |=> !acc_done[*2] ##1 acc_done)
    else $error("two-state access wrong");
  chk_slow_access: assert property (go && slow |=> !acc_done[*3] ##1 acc_done)
    else $error("three-state access wrong");
  chk_trap_start: assert property (ended && instr_class == psc_pkg::PSC_INSTR_TRAP |=> proc_class == psc_pkg::PSC_CLASS_EXC)
    else $error("trap not taken");
  chk_flag_block: assert property (ended && instr_class inside {[psc_pkg::PSC_INSTR_FLAG_AND:psc_pkg::PSC_INSTR_FLAG_LOAD]} |=> !irq_ack[*2])
    else $error("interrupt after flag op");
  chk_mask_update: assert property (sp_load |-> condition_flags_reg[7] && (user_flag_enable || condition_flags_reg[6]))
    else $error("masks not set");
  chk_sleep_entry: assert property (ended && instr_class == psc_pkg::PSC_INSTR_SLEEP && !irq_req && !irq_nmi |=> proc_class == psc_pkg::PSC_CLASS_PDOWN && clock_stop == $past(standby_select))
    else $error("sleep entry wrong");
  cover property (sp_load);
  cover property (bus_grant);
  cover property (clock_stop && hw_standby_in_n);
endmodule // psc_state_ctrl_monitor

bind psc_state_ctrl psc_state_ctrl_monitor #(.AREAS(AREAS)) mon (.*);

// File: testbench/tb.sv
// Self-checking bench for the processing-state controller.
// Assumes a 20 MHz clock and the far-side model beside the controller.
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'b0, resetn = 1'b0, reset_in_n = 1'b1, hw_standby_in_n = 1'b1, wdt_overflow = 1'b0;
  logic instr_end = 1'b0, irq_req = 1'b0, irq_nmi = 1'b0, sysctl_wr = 1'b0, core_acc_start = 1'b0, want_bus = 1'b0;
  logic sysctl_standby_select = 1'b0, sysctl_user_flag_enable = 1'b1, irq_ack, exc_mem_req, exc_mem_write, sp_load;
  logic branch_load, bus_req, bus_grant, acc_busy, acc_done, acc_wide, cpu_run, clock_stop, periph_reset;
  logic standby_select, user_flag_enable;
  logic [1:0] trap_sel = 2'h1;
  logic [2:0] core_acc_area = 3'h0, proc_class, src [3] = '{3'h7, 3'h1, 3'h2};
  logic [7:0] irq_vector = 8'h20, area_slow = 8'h0f, condition_flags_reg;
  logic [15:0] exc_mem_rdata, exc_mem_wdata;
  logic [23:0] stack_pointer_reg = 24'h00fff0, exc_mem_addr, sp_value, branch_addr;
  psc_pkg::psc_instr_type instr_class = psc_pkg::PSC_INSTR_OTHER;
  psc_pkg::psc_space_type core_acc_space = psc_pkg::PSC_SPACE_ONCHIP;
  int errors = 0, cmp_count = 0, acks = 0, n;
  psc_state_ctrl dut (.*, .return_pc(24'h001234), .ccr_wr(1'b0), .ccr_wdata(8'h00), .periph_wide(1'b1),
    .area_wide(8'h55));
  psc_far_side far (.*);
  initial forever #25 clk_sys = ~clk_sys;
  always @(posedge clk_sys) acks += irq_ack;
  task automatic check(input string what, input logic [23:0] exp, got);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic instr(input psc_pkg::psc_instr_type c);
    @(negedge clk_sys);
    instr_end = 1'b1;
    instr_class = c;
    @(negedge clk_sys);
    instr_end = 1'b0;
  endtask
  // Waits boundedly for the handler branch; the model makes each vector word address dependent.
  task automatic vector(input logic [23:0] a);
    for (n = 0; branch_load !== 1'b1 && n < 40; n++) begin
      @(negedge clk_sys);
      if (sp_load === 1'b1) check("stack", stack_pointer_reg - 24'h4, sp_value);
    end
    check("branch", {a[7:0], a[15:0] + 16'h1002}, branch_load ? branch_addr : 24'hx);
    @(negedge clk_sys);
  endtask
  task automatic access(input psc_pkg::psc_space_type s, input logic [2:0] ar, input logic [23:0] states);
    @(negedge clk_sys);
    core_acc_start = 1'b1;
    core_acc_space = s;
    core_acc_area = ar;
    @(negedge clk_sys);
    core_acc_start = 1'b0;
    for (n = 0; acc_done !== 1'b1 && n < 9; n++) @(negedge clk_sys);
    check("states", states, {n[3:0], acc_wide});
  endtask
  task automatic wake;
    {irq_req, irq_nmi} = 2'h3;
    repeat (3) @(negedge clk_sys);
    {irq_req, irq_nmi} = 2'h0;
    vector({14'h0, irq_vector, 2'h0});
  endtask
  task automatic final_report;
    $display("comparisons %0d, mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // The tests need about 200 cycles; 100 us leaves ample margin.
  initial begin
    #100us;
    errors++;
    final_report;
  end
  initial begin
    repeat (16) @(negedge clk_sys);
    resetn = 1'b1;
    vector(24'h0);
    {irq_req, irq_nmi} = 2'h3;
    for (int i = 1; i <= 4; i++) instr(psc_pkg::psc_instr_type'(i));
    check("acks", 0, acks);
    instr(psc_pkg::PSC_INSTR_TRAP);
    {irq_req, irq_nmi} = 2'h0;
    vector({14'h0, irq_vector, 2'h0});
    vector(24'h24);
    instr(psc_pkg::PSC_INSTR_SLEEP);
    check("sleep", {psc_pkg::PSC_CLASS_PDOWN, 2'h0}, {proc_class, clock_stop, periph_reset});
    wake;
    {sysctl_wr, sysctl_standby_select, sysctl_user_flag_enable} = 3'h6;
    @(negedge clk_sys) sysctl_wr = 1'b0;
    instr(psc_pkg::PSC_INSTR_SLEEP);
    check("standby", {psc_pkg::PSC_CLASS_PDOWN, 2'h3}, {proc_class, clock_stop, periph_reset});
    wake;
    check("masks", 24'h3, condition_flags_reg[7:6]);
    want_bus = 1'b1;
    repeat (3) @(negedge clk_sys);
    check("release", {psc_pkg::PSC_CLASS_BUSREL, 1'b1}, {proc_class, bus_grant});
    want_bus = 1'b0;
    repeat (3) @(negedge clk_sys);
    access(psc_pkg::PSC_SPACE_ONCHIP, 3'h0, {4'h2, 1'b1});
    access(psc_pkg::PSC_SPACE_PERIPH, 3'h0, {4'h3, 1'b1});
    access(psc_pkg::PSC_SPACE_EXTERNAL, 3'h0, {4'h3, 1'b1});
    access(psc_pkg::PSC_SPACE_EXTERNAL, 3'h7, {4'h2, 1'b0});
    for (int i = 0; i < 3; i++) begin
      {wdt_overflow, reset_in_n, hw_standby_in_n} = src[i];
      repeat (2) @(negedge clk_sys);
      check("halt", {(i < 2 ? psc_pkg::PSC_CLASS_RESET : psc_pkg::PSC_CLASS_PDOWN), 1'b1},
        {proc_class, periph_reset});
      {wdt_overflow, reset_in_n, hw_standby_in_n} = 3'h3;
      vector(24'h0);
    end
    check("acks", 3, acks);
    final_report;
  end
endmodule // tb

// File: verilog/psc_bus_cycle.sv
// Bus cycle timer: counts the states of one memory or bus access.
// Assumes start pulses only while busy is low.
module psc_bus_cycle #(
  parameter int AREAS = 8
) (
  // Clock and reset.
  input  wire logic                    clk_sys,
  input  wire logic                    resetn,
  // Access request.
  input  wire logic                    start,
  input  psc_pkg::psc_space_type       space,
  input  wire logic [$clog2(AREAS)-1:0] area,
  input  wire logic                    periph_wide,
  // Per-area setup of the external space.
  input  wire logic [AREAS-1:0]        area_wide,
  input  wire logic [AREAS-1:0]        area_slow,
  // Status.
  output logic                         busy,
  output logic                         done,
  output logic                         wide
);

  logic [1:0] count;

  // Number of states of an access to the given space.
  function automatic logic [1:0] psc_states_for(input psc_pkg::psc_space_type sp, input logic slow);
    logic [1:0] n;
    n = psc_pkg::PSC_STATES_TWO;
    if (sp == psc_pkg::PSC_SPACE_PERIPH) begin
      n = psc_pkg::PSC_STATES_THREE;
    end else if (sp == psc_pkg::PSC_SPACE_EXTERNAL && slow) begin
      n = psc_pkg::PSC_STATES_THREE;
    end
    return n;
  endfunction

  wire logic [1:0] start_states = psc_states_for(space, area_slow[area]);
  wire logic       start_wide   = (space == psc_pkg::PSC_SPACE_ONCHIP) ? 1'h1 :
                                  (space == psc_pkg::PSC_SPACE_PERIPH) ? periph_wide : area_wide[area];
  wire logic       last_state   = busy && (count == psc_pkg::PSC_STATES_LAST);

  // One count per clock edge, so each state is exactly one clock period.
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      busy  <= 1'h0;
      done  <= 1'h0;
      wide  <= 1'h0;
      count <= 2'h0;
    end else begin
      done <= last_state;
      if (start && !busy) begin
        busy  <= 1'h1;
        count <= start_states;
        wide  <= start_wide;
      end else if (last_state) begin
        busy <= 1'h0;
      end else if (busy) begin
        count <= count - psc_pkg::PSC_STATES_LAST;
      end
    end
  end

endmodule // psc_bus_cycle

// File: verilog/psc_pkg.sv
// Shared constants and types for the processing-state controller.
// Assumes a single clock domain and a core that reports instruction ends.
package psc_pkg;

  // Controller states; the usual path walks in Gray order.
  typedef enum logic [2:0] {
    PSC_ST_RESET  = 3'h0,
    PSC_ST_RSTEXC = 3'h1,
    PSC_ST_EXEC   = 3'h3,
    PSC_ST_EXC    = 3'h2,
    PSC_ST_BUSREL = 3'h6,
    PSC_ST_SLEEP  = 3'h7,
    PSC_ST_SWSTBY = 3'h5,
    PSC_ST_HWSTBY = 3'h4
  } psc_state_type;

  // Instruction classes reported by the core at instruction end.
  typedef enum logic [2:0] {
    PSC_INSTR_OTHER     = 3'h0,
    PSC_INSTR_FLAG_AND  = 3'h1,
    PSC_INSTR_FLAG_OR   = 3'h2,
    PSC_INSTR_FLAG_XOR  = 3'h3,
    PSC_INSTR_FLAG_LOAD = 3'h4,
    PSC_INSTR_TRAP      = 3'h5,
    PSC_INSTR_SLEEP     = 3'h6
  } psc_instr_type;

  // Address spaces with different access timing.
  typedef enum logic [1:0] {
    PSC_SPACE_ONCHIP   = 2'h0,
    PSC_SPACE_PERIPH   = 2'h1,
    PSC_SPACE_EXTERNAL = 2'h2
  } psc_space_type;

  // Reported processing-state class.
  localparam logic [2:0] PSC_CLASS_EXEC   = 3'h0;
  localparam logic [2:0] PSC_CLASS_EXC    = 3'h1;
  localparam logic [2:0] PSC_CLASS_PDOWN  = 3'h2;
  localparam logic [2:0] PSC_CLASS_RESET  = 3'h3;
  localparam logic [2:0] PSC_CLASS_BUSREL = 3'h4;

  // Exception sequence steps.
  localparam logic [2:0] PSC_SEQ_PUSH_HI = 3'h0;
  localparam logic [2:0] PSC_SEQ_PUSH_LO = 3'h1;
  localparam logic [2:0] PSC_SEQ_MASK    = 3'h2;
  localparam logic [2:0] PSC_SEQ_VEC_HI  = 3'h3;
  localparam logic [2:0] PSC_SEQ_VEC_LO  = 3'h4;
  localparam logic [2:0] PSC_SEQ_BRANCH  = 3'h5;
  localparam logic [2:0] PSC_SEQ_STEP    = 3'h1;

  // Flag register layout and reset values.
  localparam int         PSC_CCR_GMASK_BIT = 7;
  localparam int         PSC_CCR_UMASK_BIT = 6;
  localparam logic [7:0] PSC_CCR_RESET     = 8'h80;
  localparam logic       PSC_UE_RESET      = 1'h1;
  localparam logic       PSC_STANDBY_SELECT_RESET    = 1'h0;

  // Addressing of stack frame and vectors.
  localparam int          PSC_ADDR_W      = 24;
  localparam logic [23:0] PSC_STACK_FRAME = 24'h000004;
  localparam logic [23:0] PSC_WORD_BYTES  = 24'h000002;
  localparam logic [7:0]  PSC_VEC_RESET   = 8'h00;
  localparam logic [1:0]  PSC_VEC_PAD     = 2'h0;

  // Access lengths in states.
  localparam logic [1:0] PSC_STATES_TWO   = 2'h2;
  localparam logic [1:0] PSC_STATES_THREE = 2'h3;
  localparam logic [1:0] PSC_STATES_LAST  = 2'h1;

endpackage : psc_pkg

// File: verilog/psc_state_ctrl.sv
// Processing-state controller: execution, exceptions, reset, bus release, power-down.
// Assumes the core stalls unless cpu_run is high and reports each instruction end.
module psc_state_ctrl #(
  parameter int         AREAS            = 8,
  parameter logic [7:0] TRAP_VECTOR_BASE = 8'h08
) (
  // Clock and reset.
  input  wire logic                         clk_sys,
  input  wire logic                         resetn,
  // Device pins and watchdog.
  input  wire logic                         reset_in_n,
  input  wire logic                         hw_standby_in_n,
  input  wire logic                         wdt_overflow,
  // Instruction end report from the core.
  input  wire logic                         instr_end,
  input  psc_pkg::psc_instr_type            instr_class,
  input  wire logic [1:0]                   trap_sel,
  input  wire logic [23:0]                  return_pc,
  input  wire logic [23:0]                  stack_pointer_reg,
  // Interrupt controller.
  input  wire logic                         irq_req,
  input  wire logic                         irq_nmi,
  input  wire logic [7:0]                   irq_vector,
  output logic                              irq_ack,
  // Flag and control registers.
  input  wire logic                         ccr_wr,
  input  wire logic [7:0]                   ccr_wdata,
  output logic [7:0]                        condition_flags_reg,
  input  wire logic                         sysctl_wr,
  input  wire logic                         sysctl_standby_select,
  input  wire logic                         sysctl_user_flag_enable,
  output logic                              standby_select,
  output logic                              user_flag_enable,
  // Other bus masters.
  input  wire logic                         bus_req,
  output logic                              bus_grant,
  // Core access timing.
  input  wire logic                         core_acc_start,
  input  psc_pkg::psc_space_type            core_acc_space,
  input  wire logic [$clog2(AREAS)-1:0]     core_acc_area,
  input  wire logic                         periph_wide,
  input  wire logic [AREAS-1:0]             area_wide,
  input  wire logic [AREAS-1:0]             area_slow,
  output logic                              acc_busy,
  output logic                              acc_done,
  output logic                              acc_wide,
  // Exception sequence memory port.
  output logic                              exc_mem_req,
  output logic                              exc_mem_write,
  output logic [23:0]                       exc_mem_addr,
  output logic [15:0]                       exc_mem_wdata,
  input  wire logic [15:0]                  exc_mem_rdata,
  // Results to the core.
  output logic                              sp_load,
  output logic [23:0]                       sp_value,
  output logic                              branch_load,
  output logic [23:0]                       branch_addr,
  // State and power control.
  output logic [2:0]                        proc_class,
  output logic                              cpu_run,
  output logic                              clock_stop,
  output logic                              periph_reset
);

  psc_pkg::psc_state_type state;
  psc_pkg::psc_state_type next_state;
  logic [2:0]  step;
  logic [2:0]  next_step;
  logic        seq_wait;
  logic        irq_block;
  logic        trap_pend;
  logic [1:0]  trap_pend_sel;
  logic [7:0]  exc_vector;
  logic [23:0] ret_pc;
  logic [23:0] frame_sp;
  logic [7:0]  vec_hi;
  logic [15:0] vec_lo;

  // Pin and watchdog decode.
  wire logic reset_hold = !reset_in_n || wdt_overflow;
  wire logic hw_hw_standby_in_n    = !hw_standby_in_n;

  // State decode.
  wire logic in_exec  = (state == psc_pkg::PSC_ST_EXEC);
  wire logic in_exc   = (state == psc_pkg::PSC_ST_EXC);
  wire logic in_seq   = in_exc || (state == psc_pkg::PSC_ST_RSTEXC);
  wire logic in_sleep = (state == psc_pkg::PSC_ST_SLEEP) || (state == psc_pkg::PSC_ST_SWSTBY);
  wire logic seq_last = in_seq && (step == psc_pkg::PSC_SEQ_BRANCH);

  // Instruction-end decode.
  wire logic flag_instr = (instr_class == psc_pkg::PSC_INSTR_FLAG_AND) ||
                          (instr_class == psc_pkg::PSC_INSTR_FLAG_OR) ||
                          (instr_class == psc_pkg::PSC_INSTR_FLAG_XOR) ||
                          (instr_class == psc_pkg::PSC_INSTR_FLAG_LOAD);
  wire logic end_exec   = in_exec && instr_end;
  wire logic trap_instr = end_exec && (instr_class == psc_pkg::PSC_INSTR_TRAP);
  wire logic sleep_instr = end_exec && (instr_class == psc_pkg::PSC_INSTR_SLEEP);

  // Interrupt acceptance points; the global mask holds off all but the non-maskable request.
  wire logic irq_ok       = irq_req && (irq_nmi || !condition_flags_reg[psc_pkg::PSC_CCR_GMASK_BIT]);
  wire logic irq_at_instr = end_exec && !flag_instr && !irq_block && irq_ok;
  wire logic irq_at_seq   = in_exc && seq_last && !trap_pend && irq_ok;
  wire logic irq_at_sleep = in_sleep && irq_ok;
  wire logic take_irq     = !hw_hw_standby_in_n && !reset_hold &&
                            (irq_at_instr || irq_at_seq || irq_at_sleep);
  wire logic take_trap    = trap_instr && !irq_at_instr && !reset_hold && !hw_hw_standby_in_n;
  wire logic defer_trap   = trap_instr && irq_at_instr;
  wire logic pend_trap    = in_exc && seq_last && trap_pend && !reset_hold && !hw_hw_standby_in_n;
  wire logic start_exc    = take_irq || take_trap || pend_trap;
  wire logic go_sleep     = sleep_instr && !irq_at_instr;
  wire logic give_bus     = in_exec && bus_req && !acc_busy && !instr_end && !core_acc_start;

  // Sequencer access decode; the stack frame and the vector table are on-chip memory.
  wire logic step_access = (step == psc_pkg::PSC_SEQ_PUSH_HI) || (step == psc_pkg::PSC_SEQ_PUSH_LO) ||
                           (step == psc_pkg::PSC_SEQ_VEC_HI) || (step == psc_pkg::PSC_SEQ_VEC_LO);
  wire logic step_write  = (step == psc_pkg::PSC_SEQ_PUSH_HI) || (step == psc_pkg::PSC_SEQ_PUSH_LO);
  wire logic seq_start   = in_seq && step_access && !seq_wait && !acc_busy && !reset_hold && !hw_hw_standby_in_n;
  wire logic seq_done    = in_seq && seq_wait && acc_done;
  wire logic tmr_start   = seq_start || (in_exec && core_acc_start && !acc_busy);
  wire psc_pkg::psc_space_type tmr_space = in_seq ? psc_pkg::PSC_SPACE_ONCHIP : core_acc_space;

  // Addresses and data of the sequencer accesses.
  wire logic [23:0] frame_base = stack_pointer_reg - psc_pkg::PSC_STACK_FRAME;
  wire logic [23:0] vec_base   = psc_pkg::PSC_ADDR_W'({exc_vector, psc_pkg::PSC_VEC_PAD});
  wire logic [23:0] seq_addr   = (step == psc_pkg::PSC_SEQ_PUSH_HI) ? frame_base :
                                 (step == psc_pkg::PSC_SEQ_PUSH_LO) ? frame_base + psc_pkg::PSC_WORD_BYTES :
                                 (step == psc_pkg::PSC_SEQ_VEC_HI)  ? vec_base :
                                                                      vec_base + psc_pkg::PSC_WORD_BYTES;
  wire logic [15:0] seq_wdata  = (step == psc_pkg::PSC_SEQ_PUSH_HI) ?
                                 {condition_flags_reg, ret_pc[23:16]} : ret_pc[15:0];
  wire logic [23:0] handler    = {vec_hi, vec_lo};
  wire logic [1:0]  trap_use   = pend_trap ? trap_pend_sel : trap_sel;
  wire logic [7:0]  trap_vec   = TRAP_VECTOR_BASE + {6'h00, trap_use};

  // Next processing state; standby and reset override any sequence in flight.
  always_comb begin
    next_state = state;
    if (hw_hw_standby_in_n) begin
      next_state = psc_pkg::PSC_ST_HWSTBY;
    end else if (reset_hold) begin
      next_state = psc_pkg::PSC_ST_RESET;
    end else begin
      unique case (state)
        psc_pkg::PSC_ST_RESET: begin
          next_state = psc_pkg::PSC_ST_RSTEXC;
        end
        psc_pkg::PSC_ST_HWSTBY: begin
          next_state = psc_pkg::PSC_ST_RESET;
        end
        psc_pkg::PSC_ST_RSTEXC: begin
          if (seq_last) begin
            next_state = psc_pkg::PSC_ST_EXEC;
          end
        end
        psc_pkg::PSC_ST_EXEC: begin
          if (start_exc) begin
            next_state = psc_pkg::PSC_ST_EXC;
          end else if (go_sleep) begin
            next_state = standby_select ? psc_pkg::PSC_ST_SWSTBY : psc_pkg::PSC_ST_SLEEP;
          end else if (give_bus) begin
            next_state = psc_pkg::PSC_ST_BUSREL;
          end
        end
        psc_pkg::PSC_ST_EXC: begin
          if (seq_last) begin
            next_state = start_exc ? psc_pkg::PSC_ST_EXC : psc_pkg::PSC_ST_EXEC;
          end
        end
        psc_pkg::PSC_ST_BUSREL: begin
          if (!bus_req) begin
            next_state = psc_pkg::PSC_ST_EXEC;
          end
        end
        psc_pkg::PSC_ST_SLEEP, psc_pkg::PSC_ST_SWSTBY: begin
          if (take_irq) begin
            next_state = psc_pkg::PSC_ST_EXC;
          end
        end
      endcase
    end
  end

  // Next sequence step; a reset exception starts at PSC_SEQ_VEC_HI, any other fresh exception restarts from the first step.
  always_comb begin
    next_step = step;
    if (next_state == psc_pkg::PSC_ST_EXC && (!in_exc || seq_last)) begin
      next_step = psc_pkg::PSC_SEQ_PUSH_HI;
    end else if (next_state == psc_pkg::PSC_ST_RSTEXC && !in_seq) begin
      next_step = psc_pkg::PSC_SEQ_VEC_HI;
    end else if (in_seq) begin
      if (seq_done) begin
        next_step = step + psc_pkg::PSC_SEQ_STEP;
      end else if (step == psc_pkg::PSC_SEQ_MASK) begin
        next_step = psc_pkg::PSC_SEQ_VEC_HI;
      end
    end
  end

  // State register.
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      state <= psc_pkg::PSC_ST_RESET;
      step  <= psc_pkg::PSC_SEQ_VEC_HI;
    end else begin
      state <= next_state;
      step  <= next_step;
    end
  end

  // Interrupt blocking after reset lasts until the first instruction has ended.
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      irq_block <= 1'h1;
    end else if (next_state == psc_pkg::PSC_ST_RESET || in_seq && !in_exc) begin
      irq_block <= 1'h1;
    end else if (end_exec) begin
      irq_block <= 1'h0;
    end
  end

  // A trap that loses to an interrupt at the same instruction end runs right after it.
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      trap_pend     <= 1'h0;
      trap_pend_sel <= 2'h0;
    end else if (reset_hold || hw_hw_standby_in_n) begin
      trap_pend <= 1'h0;
    end else if (defer_trap) begin
      trap_pend     <= 1'h1;
      trap_pend_sel <= trap_sel;
    end else if (pend_trap) begin
      trap_pend <= 1'h0;
    end
  end

  // Vector number and return address of the exception being served.
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      exc_vector <= psc_pkg::PSC_VEC_RESET;
      ret_pc     <= 24'h000000;
    end else if (next_state == psc_pkg::PSC_ST_RESET) begin
      exc_vector <= psc_pkg::PSC_VEC_RESET;
    end else if (take_irq) begin
      exc_vector <= irq_vector;
      ret_pc     <= irq_at_seq ? handler : return_pc;
    end else if (take_trap || pend_trap) begin
      exc_vector <= trap_vec;
      ret_pc     <= pend_trap ? handler : return_pc;
    end
  end

  // Flag register: reset and the mask step win over a core write, which cannot coincide anyway.
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      condition_flags_reg <= psc_pkg::PSC_CCR_RESET;
    end else if (state == psc_pkg::PSC_ST_RESET) begin
      condition_flags_reg[psc_pkg::PSC_CCR_GMASK_BIT] <= 1'h1;
    end else if (in_exc && step == psc_pkg::PSC_SEQ_MASK) begin
      condition_flags_reg[psc_pkg::PSC_CCR_GMASK_BIT] <= 1'h1;
      if (!user_flag_enable) begin
        condition_flags_reg[psc_pkg::PSC_CCR_UMASK_BIT] <= 1'h1;
      end
    end else if (ccr_wr && in_exec) begin
      condition_flags_reg <= ccr_wdata;
    end
  end

  // System control bits; standby select survives a software standby exit until software clears it, and hardware standby clears it.
  always_ff @(posedge clk_sys) begin
    if (!resetn || state == psc_pkg::PSC_ST_HWSTBY) begin
      standby_select   <= psc_pkg::PSC_STANDBY_SELECT_RESET;
      user_flag_enable <= psc_pkg::PSC_UE_RESET;
    end else if (sysctl_wr && in_exec) begin
      standby_select   <= sysctl_standby_select;
      user_flag_enable <= sysctl_user_flag_enable;
    end
  end

  // Sequencer handshake with the cycle timer; a late completion after an abort is ignored.
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      seq_wait <= 1'h0;
      vec_hi   <= 8'h00;
      vec_lo   <= 16'h0000;
      frame_sp <= 24'h000000;
    end else begin
      if (seq_start) begin
        seq_wait <= 1'h1;
      end else if (seq_done || reset_hold || hw_hw_standby_in_n) begin
        seq_wait <= 1'h0;
      end
      if (seq_done && step == psc_pkg::PSC_SEQ_VEC_HI) begin
        vec_hi <= exc_mem_rdata[7:0];
      end
      if (seq_done && step == psc_pkg::PSC_SEQ_VEC_LO) begin
        vec_lo <= exc_mem_rdata;
      end
      if (seq_start && step == psc_pkg::PSC_SEQ_PUSH_HI) begin
        frame_sp <= frame_base;
      end
    end
  end

  // Memory port and results of the exception sequence.
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      exc_mem_req   <= 1'h0;
      exc_mem_write <= 1'h0;
      exc_mem_addr  <= 24'h000000;
      exc_mem_wdata <= 16'h0000;
      sp_load       <= 1'h0;
      sp_value      <= 24'h000000;
      branch_load   <= 1'h0;
      branch_addr   <= 24'h000000;
      irq_ack       <= 1'h0;
    end else begin
      exc_mem_req <= seq_start;
      if (seq_start) begin
        exc_mem_write <= step_write;
        exc_mem_addr  <= seq_addr;
        exc_mem_wdata <= seq_wdata;
      end
      sp_load     <= in_exc && step == psc_pkg::PSC_SEQ_MASK && !reset_hold && !hw_hw_standby_in_n;
      sp_value    <= frame_sp;
      branch_load <= seq_last && !reset_hold && !hw_hw_standby_in_n;
      branch_addr <= handler;
      irq_ack     <= take_irq;
    end
  end

  // Registered view of the next state for the core and the power logic.
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      proc_class   <= psc_pkg::PSC_CLASS_RESET;
      cpu_run      <= 1'h0;
      bus_grant    <= 1'h0;
      clock_stop   <= 1'h0;
      periph_reset <= 1'h1;
    end else begin
      unique case (next_state)
        psc_pkg::PSC_ST_EXEC:                          proc_class <= psc_pkg::PSC_CLASS_EXEC;
        psc_pkg::PSC_ST_EXC, psc_pkg::PSC_ST_RSTEXC:   proc_class <= psc_pkg::PSC_CLASS_EXC;
        psc_pkg::PSC_ST_BUSREL:                        proc_class <= psc_pkg::PSC_CLASS_BUSREL;
        psc_pkg::PSC_ST_RESET:                         proc_class <= psc_pkg::PSC_CLASS_RESET;
        psc_pkg::PSC_ST_SLEEP, psc_pkg::PSC_ST_SWSTBY,
        psc_pkg::PSC_ST_HWSTBY:                        proc_class <= psc_pkg::PSC_CLASS_PDOWN;
      endcase
      cpu_run      <= (next_state == psc_pkg::PSC_ST_EXEC);
      bus_grant    <= (next_state == psc_pkg::PSC_ST_BUSREL);
      clock_stop   <= (next_state == psc_pkg::PSC_ST_SWSTBY) ||
                      (next_state == psc_pkg::PSC_ST_HWSTBY);
      periph_reset <= (next_state == psc_pkg::PSC_ST_SWSTBY) ||
                      (next_state == psc_pkg::PSC_ST_HWSTBY) ||
                      (next_state == psc_pkg::PSC_ST_RESET);
    end
  end

  // Shared access timer for the core and the exception sequence.
  psc_bus_cycle #(
    .AREAS (AREAS)
  ) u_cycle (
    .clk_sys     (clk_sys),
    .resetn      (resetn),
    .start       (tmr_start),
    .space       (tmr_space),
    .area        (core_acc_area),
    .periph_wide (periph_wide),
    .area_wide   (area_wide),
    .area_slow   (area_slow),
    .busy        (acc_busy),
    .done        (acc_done),
    .wide        (acc_wide)
  );

endmodule // psc_state_ctrl
